// *** rtl/auto_measure_cfg.svh ***
`ifndef AUTO_MEASURE_CFG_SVH
`define AUTO_MEASURE_CFG_SVH
`define OPC_RESET        16'h0000
`define OPC_THR_HI       12
`define OPC_THR_LO       8
`define OPC_MODE_HI      7
`define OPC_MODE_LO      6
`define OPC_DLY_HI       3
`define OPC_DLY_LO       0
`define CFG_RATIO_HI     10
`define CFG_RATIO_LO     8
`define CFG_FILT_HI      7
`define CFG_FILT_LO      5
`define FLAG_FULL_BIT    2
`define FLAG_THR_BIT     1
`define FIFO_DEPTH       32
`define CLK_HZ           50000000
`define BUSY_CYCLES      4
`endif

// *** rtl/auto_measure_pkg.sv ***
package auto_measure_pkg;
    typedef enum logic [1:0] {
        FIFO_OFF,
        FIFO_STOP,
        FIFO_OVR_A,
        FIFO_OVR_B
    } fifo_mode_t;

    typedef struct packed {
        logic [23:0] pressure;
        logic [23:0] temperature;
    } sample_pair_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] cmd;
    } host_cmd_t;

    typedef struct packed {
        logic        start_p;
        logic        start_t;
    } conv_req_t;
endpackage

// *** rtl/auto_measure_filter_fifo.sv ***
`timescale 1ns/1ps
`include "auto_measure_cfg.svh"
module auto_measure_filter_fifo #(
    parameter int unsigned MS_CYCLES = `CLK_HZ / 1000
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire logic                          link_clk,
    input  wire logic                          link_rst,
    input  wire logic                          op_wr,
    input  wire logic [15:0]                   op_wdata,
    input  wire logic                          cfg_wr,
    input  wire logic                          cfg_sel_t,
    input  wire logic [15:0]                   cfg_wdata,
    input  wire auto_measure_pkg::host_cmd_t   link_cmd,
    input  wire logic                          fifo_rd,
    input  wire logic                          conv_done,
    input  wire logic                          conv_is_t,
    input  wire logic [23:0]                   conv_data,
    output logic [15:0]                        op_rdata,
    output logic [15:0]                        cfg_p_q,
    output logic [15:0]                        cfg_t_q,
    output auto_measure_pkg::conv_req_t        conv_req_q,
    output logic                               mclk_en_q,
    output logic                               sdo_busy_q,
    output logic                               auto_active_q,
    output logic                               cmd_reject_q,
    output logic                               cmd_accept_q,
    output logic [7:0]                         cmd_q,
    output auto_measure_pkg::sample_pair_t     fifo_rdata_q,
    output logic                               fifo_rvalid_q,
    output logic [23:0]                        p_out_q,
    output logic [23:0]                        t_out_q,
    output logic [2:0]                         flags_q,
    output logic [5:0]                         fifo_count_q
);
    // Link-side command capture, handed over by toggle
    logic        lk_tgl_q;
    logic [7:0]  lk_cmd_q;
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            lk_tgl_q <= 1'b0;
            lk_cmd_q <= 8'h00;
        end else if (link_cmd.valid) begin
            lk_tgl_q <= ~lk_tgl_q;
            lk_cmd_q <= link_cmd.cmd;
        end
    end

    logic [2:0] tgl_sync_q;
    logic       cmd_new;
    logic [7:0] cmd_lat;
    always_ff @(posedge clk) begin
        if (rst)
            tgl_sync_q <= 3'h0;
        else if (ce)
            tgl_sync_q <= {tgl_sync_q[1:0], lk_tgl_q};
    end
    // Command word is stable once the toggle has been seen twice
    assign cmd_new = tgl_sync_q[2] ^ tgl_sync_q[1];
    assign cmd_lat = lk_cmd_q;

    // Operation register
    logic [15:0] op_q;
    logic [3:0]  dly_code;
    logic [1:0]  mode_f;
    logic [4:0]  thr_f;
    assign dly_code = op_q[`OPC_DLY_HI:`OPC_DLY_LO];
    assign mode_f   = op_q[`OPC_MODE_HI:`OPC_MODE_LO];
    assign thr_f    = op_q[`OPC_THR_HI:`OPC_THR_LO];
    always_ff @(posedge clk) begin
        if (rst)
            op_q <= `OPC_RESET;
        else if (ce && op_wr)
            op_q <= {3'h0, op_wdata[12:6], 2'h0, op_wdata[3:0]};
    end

    // Ratio decode
    function automatic logic [5:0] ratio_of(input logic [2:0] c);
        unique case (c)
            3'h0: ratio_of = 6'h00;
            3'h1: ratio_of = 6'h01;
            3'h2: ratio_of = 6'h02;
            3'h3: ratio_of = 6'h04;
            3'h4: ratio_of = 6'h08;
            3'h5: ratio_of = 6'h10;
            default: ratio_of = 6'h20;
        endcase
    endfunction
    // Filter shift: log2 of k, zero means off
    function automatic logic [2:0] fshift_of(input logic [2:0] c);
        fshift_of = (c > 3'h5) ? 3'h5 : c;
    endfunction
    function automatic logic [31:0] delay_ms(input logic [3:0] c);
        unique case (c)
            4'h0: delay_ms = 32'h0;
            4'h1: delay_ms = 32'd5;
            4'h2: delay_ms = 32'd10;
            4'h3: delay_ms = 32'd20;
            4'h4: delay_ms = 32'd50;
            4'h5: delay_ms = 32'd100;
            4'h6: delay_ms = 32'd200;
            4'h7: delay_ms = 32'd500;
            4'h8: delay_ms = 32'd1000;
            4'h9: delay_ms = 32'd2000;
            4'hA: delay_ms = 32'd5000;
            4'hB: delay_ms = 32'd10000;
            4'hC: delay_ms = 32'd20000;
            default: delay_ms = 32'd60000;
        endcase
    endfunction

    logic [5:0] rp;
    logic [5:0] rt;
    assign rp = ratio_of(cfg_p_q[`CFG_RATIO_HI:`CFG_RATIO_LO]);
    assign rt = ratio_of(cfg_t_q[`CFG_RATIO_HI:`CFG_RATIO_LO]);

    // Command classes: conversion 010 0xxxx, write config 0010000x, service 1xxxxxxx
    logic is_conv;
    logic is_wcfg;
    logic is_svc;
    assign is_conv = (cmd_lat[7:4] == 4'h4);
    assign is_wcfg = (cmd_lat[7:1] == 7'h10);
    assign is_svc  = cmd_lat[7];
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_reject_q <= 1'b0;
            cmd_accept_q <= 1'b0;
            cmd_q        <= 8'h00;
        end else if (ce) begin
            // Word is taken only once the toggle says it has settled
            if (cmd_new)
                cmd_q <= cmd_lat;
            cmd_reject_q <= cmd_new && auto_active_q && (is_conv || is_wcfg);
            cmd_accept_q <= cmd_new && !(auto_active_q && (is_conv || is_wcfg || is_svc));
        end
    end

    // Channel configuration, locked while automatic
    // Writes in automatic mode are dropped, not queued
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_p_q <= 16'h0000;
            cfg_t_q <= 16'h0000;
        end else if (ce && cfg_wr && !auto_active_q) begin
            if (cfg_sel_t)
                cfg_t_q <= cfg_wdata;
            else
                cfg_p_q <= cfg_wdata;
        end
    end

    // Automatic sequencer
    typedef enum logic [1:0] {A_IDLE, A_WAIT, A_CONV, A_BUSY} auto_st_t;
    auto_st_t    st_q;
    logic [31:0] ms_left_q;
    logic [31:0] tick_q;
    logic [5:0]  evt_q;
    logic        pend_p_q;
    logic        pend_t_q;
    logic [2:0]  busy_q;
    logic        go_p;
    logic        go_t;
    logic        start_req;
    assign start_req = op_wr && (op_wdata[3:0] != 4'h0) && ((rp != 6'h00) || (rt != 6'h00));
    assign go_p = (rp != 6'h00) && ((evt_q & (rp - 6'h01)) == 6'h00);
    assign go_t = (rt != 6'h00) && ((evt_q & (rt - 6'h01)) == 6'h00);

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q          <= A_IDLE;
            ms_left_q     <= 32'h0;
            tick_q        <= 32'h0;
            evt_q         <= 6'h00;
            pend_p_q      <= 1'b0;
            pend_t_q      <= 1'b0;
            busy_q        <= 3'h0;
            conv_req_q    <= '0;
            mclk_en_q     <= 1'b0;
            sdo_busy_q    <= 1'b0;
            auto_active_q <= 1'b0;
        end else if (ce) begin
            conv_req_q <= '0;
            if (start_req) begin
                // Start straight away, timer restarts
                st_q          <= A_WAIT;
                ms_left_q     <= 32'h0;
                tick_q        <= 32'h0;
                auto_active_q <= 1'b1;
            end else begin
                unique case (st_q)
                    A_IDLE: auto_active_q <= 1'b0;
                    A_WAIT: begin
                        if (dly_code == 4'h0) begin
                            st_q  <= A_IDLE;
                            evt_q <= 6'h00;
                        end else if (ms_left_q != 32'h0) begin
                            if (tick_q == MS_CYCLES - 1) begin
                                tick_q    <= 32'h0;
                                ms_left_q <= ms_left_q - 32'h1;
                            end else begin
                                tick_q <= tick_q + 32'h1;
                            end
                        end else if (go_p || go_t) begin
                            conv_req_q <= '{start_p: go_p, start_t: go_t};
                            pend_p_q   <= go_p;
                            pend_t_q   <= go_t;
                            st_q       <= A_CONV;
                        end else begin
                            // Nothing due: keep the sequencer clock alive briefly
                            mclk_en_q  <= 1'b1;
                            sdo_busy_q <= 1'b1;
                            busy_q     <= 3'(`BUSY_CYCLES - 1);
                            st_q       <= A_BUSY;
                        end
                    end
                    A_CONV: begin
                        if (conv_done) begin
                            if (conv_is_t)
                                pend_t_q <= 1'b0;
                            else
                                pend_p_q <= 1'b0;
                        end
                        if (!(pend_p_q || pend_t_q)) begin
                            if (dly_code == 4'h0) begin
                                st_q  <= A_IDLE;
                                evt_q <= 6'h00;
                            end else begin
                                st_q      <= A_WAIT;
                                evt_q     <= (evt_q == 6'h1F) ? 6'h00 : evt_q + 6'h01;
                                ms_left_q <= delay_ms(dly_code);
                            end
                        end
                    end
                    A_BUSY: begin
                        if (busy_q == 3'h0) begin
                            mclk_en_q  <= 1'b0;
                            sdo_busy_q <= 1'b0;
                            if (dly_code == 4'h0) begin
                                st_q  <= A_IDLE;
                                evt_q <= 6'h00;
                            end else begin
                                st_q      <= A_WAIT;
                                evt_q     <= (evt_q == 6'h1F) ? 6'h00 : evt_q + 6'h01;
                                ms_left_q <= delay_ms(dly_code);
                            end
                        end else begin
                            busy_q <= busy_q - 3'h1;
                        end
                    end
                endcase
            end
        end
    end

    // Filters, one per channel
    logic        on_p_q;
    logic        on_t_q;
    logic [2:0]  sp;
    logic [2:0]  stt;
    logic [23:0] filt_p;
    logic [23:0] filt_t;
    assign sp     = fshift_of(cfg_p_q[`CFG_FILT_HI:`CFG_FILT_LO]);
    assign stt    = fshift_of(cfg_t_q[`CFG_FILT_HI:`CFG_FILT_LO]);
    // Truncating shifts lose a little precision for large k
    assign filt_p = p_out_q - (p_out_q >> sp) + (conv_data >> sp);
    assign filt_t = t_out_q - (t_out_q >> stt) + (conv_data >> stt);
    // Only the last result of an event pushes, so pairs stay whole
    logic        fifo_push_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            p_out_q     <= 24'h000000;
            t_out_q     <= 24'h000000;
            on_p_q      <= 1'b0;
            on_t_q      <= 1'b0;
            fifo_push_q <= 1'b0;
        end else if (ce) begin
            fifo_push_q <= 1'b0;
            if (sp == 3'h0)
                on_p_q <= 1'b0;
            if (stt == 3'h0)
                on_t_q <= 1'b0;
            if (conv_done && conv_is_t) begin
                t_out_q <= (on_t_q && stt != 3'h0) ? filt_t : conv_data;
                on_t_q  <= (stt != 3'h0);
                fifo_push_q <= !pend_p_q;
            end
            if (conv_done && !conv_is_t) begin
                p_out_q <= (on_p_q && sp != 3'h0) ? filt_p : conv_data;
                on_p_q  <= (sp != 3'h0);
                fifo_push_q <= !pend_t_q;
            end
        end
    end

    // FIFO of result pairs
    auto_measure_pkg::sample_pair_t mem_q [`FIFO_DEPTH];
    logic [4:0] wp_q;
    logic [4:0] rp_q;
    logic [5:0] cnt_q;
    logic       ovr;
    logic       fifo_on;
    logic       wr_ok;
    logic       rd_ok;
    assign fifo_on = (mode_f != 2'h0);
    assign ovr     = mode_f[1];
    // Overwrite keeps one slot free so the pointers never meet
    assign wr_ok   = fifo_push_q && fifo_on &&
                     (ovr || cnt_q != 6'(`FIFO_DEPTH));
    assign rd_ok   = fifo_rd && fifo_on && cnt_q != 6'h00;
    always_ff @(posedge clk) begin
        if (ce && wr_ok)
            mem_q[wp_q] <= '{pressure: p_out_q, temperature: t_out_q};
    end
    always_ff @(posedge clk) begin
        if (rst || (ce && !fifo_on)) begin
            wp_q          <= 5'h00;
            rp_q          <= 5'h00;
            cnt_q         <= 6'h00;
            fifo_rvalid_q <= 1'b0;
            fifo_rdata_q  <= '0;
        end else if (ce) begin
            fifo_rvalid_q <= rd_ok;
            if (rd_ok) begin
                fifo_rdata_q <= mem_q[rp_q];
                rp_q         <= rp_q + 5'h01;
            end
            if (wr_ok)
                wp_q <= wp_q + 5'h01;
            // Read and push together leave the count as it was
            if (wr_ok && ovr && cnt_q == 6'h1F && !rd_ok)
                rp_q <= rp_q + 5'h01;
            else if (wr_ok && !rd_ok)
                cnt_q <= cnt_q + 6'h01;
            else if (rd_ok && !wr_ok)
                cnt_q <= cnt_q - 6'h01;
        end
    end

    // Flags look at the count one cycle after the push has landed
    logic        flag_eval_q;
    always_ff @(posedge clk) begin
        if (rst)
            flag_eval_q <= 1'b0;
        else if (ce)
            flag_eval_q <= fifo_push_q;
    end

    // Flags, evaluated at conversion end; full and threshold also cleared while the FIFO is off
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= 3'h0;
        end else if (ce) begin
            if (!fifo_on)
                flags_q <= 3'h0;
            else if (flag_eval_q) begin
                flags_q[`FLAG_FULL_BIT] <= (cnt_q == 6'(`FIFO_DEPTH));
                flags_q[`FLAG_THR_BIT]  <= (thr_f != 5'h00) &&
                                           (cnt_q >= {1'b0, thr_f});
            end
            flags_q[0] <= conv_done;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_rdata     <= 16'h0000;
            fifo_count_q <= 6'h00;
        end else if (ce) begin
            op_rdata     <= op_q;
            fifo_count_q <= cnt_q;
        end
    end
endmodule

// *** dv/auto_measure_filter_fifo_properties.sv ***
`timescale 1ns/1ps
module auto_measure_filter_fifo_properties (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        op_wr,
    input wire logic [15:0] op_wdata,
    input wire logic        cfg_wr,
    input wire logic        cfg_sel_t,
    input wire logic [15:0] cfg_wdata,
    input wire logic [15:0] op_rdata,
    input wire logic [15:0] cfg_p_q,
    input wire logic [15:0] cfg_t_q,
    input wire logic        mclk_en_q,
    input wire logic        sdo_busy_q,
    input wire logic        auto_active_q,
    input wire logic [2:0]  flags_q,
    input wire logic [5:0]  fifo_count_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic ron;
    logic pw;
    // Auto start needs at least one channel with a ratio
    assign ron = cfg_p_q[10:8] != 3'h0 || cfg_t_q[10:8] != 3'h0;
    assign pw = cfg_wr && ce && !cfg_sel_t;
    property p_op_fields;
        op_wr && ce |=> ##1 (op_rdata & 16'h1FCF) == ($past(op_wdata, 2) & 16'h1FCF);
    endproperty
    a_op_fields: assert property (p_op_fields) else $error("op word lost");
    property p_auto_on;
        op_wr && ce && op_wdata[3:0] != 4'h0 && ron |=> auto_active_q;
    endproperty
    a_auto_on: assert property (p_auto_on) else $error("auto not started");
    property p_auto_off;
        op_wr && ce && !ron && !auto_active_q |=> !auto_active_q;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("auto without ratios");
    property p_cfg_hold; pw && auto_active_q |=> $stable(cfg_p_q); endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config taken in auto");
    property p_cfg_take;
        pw && !auto_active_q |=> ((cfg_p_q ^ $past(cfg_wdata)) & 16'h07E0) == 16'h0000;
    endproperty
    a_cfg_take: assert property (p_cfg_take) else $error("config not stored");
    property p_busy; $rose(sdo_busy_q) |-> (sdo_busy_q && mclk_en_q)[*4] ##1 !sdo_busy_q; endproperty
    a_busy: assert property (p_busy) else $error("idle event busy shape");
    property p_count_max; fifo_count_q <= 6'h20; endproperty
    a_count_max: assert property (p_count_max) else $error("count above depth");
    property p_full; $rose(flags_q[2]) |-> fifo_count_q == 6'h20; endproperty
    a_full: assert property (p_full) else $error("full flag early");
    property p_thr_zero; $rose(flags_q[1]) |-> (op_rdata & 16'h1F00) != 16'h0000; endproperty
    a_thr_zero: assert property (p_thr_zero) else $error("threshold flag at zero");
    property p_fifo_off; op_rdata[7:6] == 2'h0 |=> fifo_count_q == 6'h00; endproperty
    a_fifo_off: assert property (p_fifo_off) else $error("fifo not emptied");
endmodule

bind auto_measure_filter_fifo auto_measure_filter_fifo_properties u_props (
    .clk(clk), .rst(rst), .ce(ce), .op_wr(op_wr), .op_wdata(op_wdata),
    .cfg_wr(cfg_wr), .cfg_sel_t(cfg_sel_t), .cfg_wdata(cfg_wdata),
    .op_rdata(op_rdata), .cfg_p_q(cfg_p_q), .cfg_t_q(cfg_t_q),
    .mclk_en_q(mclk_en_q), .sdo_busy_q(sdo_busy_q), .auto_active_q(auto_active_q),
    .flags_q(flags_q), .fifo_count_q(fifo_count_q)
);

// *** dv/adc_model.sv ***
`timescale 1ns/1ps
module adc_model (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [3:0]                  lat,
    input  wire auto_measure_pkg::conv_req_t req,
    output logic                             done,
    output logic                             is_t,
    output logic [23:0]                      data
);
    logic        pp;
    logic        pt;
    logic [3:0]  cnt;
    logic [23:0] last;
    logic [31:0] rnd;
    always_ff @(posedge clk) rnd <= $urandom();
    // Pressure first, then temperature, each after lat+1 cycles
    always_ff @(posedge clk) begin
        done <= 1'b0;
        data <= ~last;  // No stale value between results
        if (rst) begin
            pp <= 1'b0;
            pt <= 1'b0;
            cnt <= 4'h0;
            is_t <= 1'b0;
            last <= 24'h000000;
        end else if (req.start_p || req.start_t) begin
            pp <= req.start_p;
            pt <= req.start_t;
            cnt <= lat;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (pp || pt) begin
            done <= 1'b1;
            is_t <= !pp;
            data <= rnd[23:0];
            last <= rnd[23:0];
            pp <= 1'b0;
            pt <= pp && pt;
            cnt <= lat;
        end
    end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic op_wr = 1'b0;
    logic cfg_wr = 1'b0;
    logic cfg_sel_t = 1'b0;
    logic fifo_rd = 1'b0;
    logic [15:0] op_wdata = 16'h0000;
    logic [15:0] cfg_wdata = 16'h0000;
    logic [3:0] lat = 4'h2;
    auto_measure_pkg::host_cmd_t link_cmd = '0;
    auto_measure_pkg::conv_req_t conv_req_q;
    auto_measure_pkg::sample_pair_t fifo_rdata_q;
    auto_measure_pkg::sample_pair_t q[$];
    logic conv_done, conv_is_t, mclk_en_q, sdo_busy_q, auto_active_q;
    logic cmd_reject_q, cmd_accept_q, fifo_rvalid_q;
    logic [15:0] op_rdata, cfg_p_q, cfg_t_q;
    logic [23:0] conv_data, p_out_q, t_out_q;
    logic [7:0] cmd_q;
    logic [2:0] flags_q;
    logic [5:0] fifo_count_q;
    logic [7:0] lc[4] = '{8'h44, 8'h20, 8'hE0, 8'h16};
    int dms[4] = '{0, 5, 10, 20};
    int err_count, tests_run, cyc, ev, outst, nreq, n0, fchk, rp, rt, kp, thr, mode, dly, fp, lt;
    int gap = -1;
    bit seeded, busy_d, idle;
    always #10 clk = ~clk;
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    auto_measure_filter_fifo #(.MS_CYCLES(10)) DUT (
        .clk, .rst, .ce(1'b1), .link_clk, .link_rst(rst), .op_wr, .op_wdata, .cfg_wr,
        .cfg_sel_t, .cfg_wdata, .link_cmd, .fifo_rd, .conv_done, .conv_is_t, .conv_data,
        .op_rdata, .cfg_p_q, .cfg_t_q, .conv_req_q, .mclk_en_q, .sdo_busy_q, .auto_active_q,
        .cmd_reject_q, .cmd_accept_q, .cmd_q, .fifo_rdata_q, .fifo_rvalid_q, .p_out_q,
        .t_out_q, .flags_q, .fifo_count_q);
    adc_model u_adc (.clk, .rst, .lat, .req(conv_req_q), .done(conv_done), .is_t(conv_is_t),
        .data(conv_data));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    function automatic bit due(int r);
        return r != 0 && ev % r == 0;
    endfunction
    function automatic int rdec(int c);
        return c == 0 ? 0 : c >= 6 ? 32 : 1 << (c - 1);
    endfunction
    // Bench model of scheduling, filter and fifo, updated at every edge
    always @(posedge clk) begin
        cyc++;
        if (cyc > 30000) begin
            err_count++;
            wrap_up();
        end
        idle = !rst && sdo_busy_q === 1'b1 && !busy_d;
        if (busy_d && sdo_busy_q === 1'b0) gap = 0;
        busy_d = sdo_busy_q;
        if (gap >= 0) gap++;
        if (fchk == 1) chk({p_out_q, t_out_q}, {fp[23:0], lt[23:0]}, "filter out");
        if (fchk > 0) fchk--;
        if ((!rst && conv_req_q !== 2'b00) || idle) begin
            chk(conv_req_q, {due(rp), due(rt)}, "scheduled channels");
            if (ev > 0 && gap >= 0) chk(gap >= dly && gap <= dly + 4, 1, "event delay");
            gap = -1;
            outst += conv_req_q.start_p + conv_req_q.start_t;
            nreq += !idle;
            ev++;
        end
        if (conv_done === 1'b1) begin
            if (conv_is_t) lt = conv_data;
            else if (kp == 0 || !seeded) fp = conv_data;
            else fp = fp - fp / kp + conv_data / kp;
            seeded |= !conv_is_t;
            fchk = conv_is_t ? fchk : 2;
            outst--;
            if (outst == 0) begin
                gap = 0;
                if (mode == 1 && q.size() < 32) q.push_back({fp[23:0], lt[23:0]});
                if (mode >= 2 && q.size() == 31) void'(q.pop_front());
                if (mode >= 2) q.push_back({fp[23:0], lt[23:0]});
            end
        end
        if (fifo_rvalid_q === 1'b1) chk(fifo_rdata_q, q.size() ? q.pop_front() : '0, "entry");
    end
    task automatic opw(input logic [15:0] v);
        @(posedge clk);
        op_wr <= 1'b1;
        op_wdata <= v;
        @(posedge clk);
        op_wr <= 1'b0;
        mode = v[7:6];
        thr = v[12:8];
        dly = dms[v[1:0]] * 10;
        if (v[3:0] != 4'h0) ev = 0;
        if (v[7:6] == 2'h0) q.delete();
    endtask
    task automatic cfgw(input logic t, input logic [15:0] v);
        if (!auto_active_q && t) rt = rdec(v[10:8]);
        if (!auto_active_q && !t) begin
            seeded = seeded && kp != 0;
            rp = rdec(v[10:8]);
            kp = v[7:5] == 3'h0 ? 0 : v[7:5] >= 3'h5 ? 32 : 1 << v[7:5];
        end
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_sel_t <= t;
        cfg_wdata <= v;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    task automatic lsend(input logic [7:0] c, input logic acc);
        logic [1:0] seen;
        @(posedge link_clk);
        link_cmd <= '{1'b1, c};
        @(posedge link_clk);
        link_cmd <= '{1'b0, ~c};
        seen = 2'b00;
        repeat (8) begin
            @(posedge clk);
            seen = seen | {cmd_accept_q === 1'b1, cmd_reject_q === 1'b1};
        end
        chk({seen, cmd_q}, {acc, !acc && !c[7], c}, "command verdict");
        repeat (4) @(posedge clk);
    endtask
    task automatic evs(input int n);
        int k;
        k = 0;
        n += ev;
        while ((ev < n || outst != 0) && k < 20000) begin
            @(posedge clk);
            k++;
        end
        chk(k < 20000, 1, "event wait");
        repeat (4) @(posedge clk);
    endtask
    task automatic rd(input int n);
        int k;
        repeat (n) begin
            @(posedge clk);
            fifo_rd <= 1'b1;
            @(posedge clk);
            fifo_rd <= 1'b0;
            k = 0;
            while (fifo_rvalid_q !== 1'b1 && k < 8) begin
                @(posedge clk);
                k++;
            end
            chk(k < 8, 1, "read answer");
        end
    endtask
    task automatic state();
        chk(fifo_count_q, q.size(), "entry count");
        chk(flags_q[2:1], {q.size() == 32, thr != 0 && q.size() >= thr}, "flags");
    endtask
    initial begin
        void'($urandom(5));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({op_rdata, cfg_p_q, cfg_t_q, fifo_count_q}, 0, "reset state");
        opw(16'h0001);
        repeat (3) @(posedge clk);
        chk(auto_active_q, 0, "auto without ratios");
        opw(16'h0000);
        cfgw(0, 16'h0140 | (16'($urandom()) & 16'hF800));
        cfgw(1, 16'h0300);
        opw(16'h0541);
        foreach (lc[i]) lsend(lc[i], i == 3);
        cfgw(0, 16'h0200);
        evs(36);
        while (conv_req_q === 2'b00) @(posedge clk);
        opw(16'h0540);
        n0 = nreq;
        repeat (200) @(posedge clk);
        chk({auto_active_q, outst == 0, nreq == n0}, 3'b011, "stop completes set");
        state();
        rd(30);
        opw(16'h0000);
        repeat (3) @(posedge clk);
        chk(fifo_count_q, 0, "fifo cleared");
        cfgw(0, 16'h0200);
        lat <= 4'h9;
        opw(16'h0082);
        evs(72);
        opw(16'h00C0);
        repeat (12) @(posedge clk);
        evs(0);
        state();
        rd(31);
        wrap_up();
    end
endmodule
